// [rtl/cpmc_consts.vh]
/*
 constants for the clock and power-mode control block: register offsets,
 field positions, reset values and timing figures.
 assumes a 250 MHz pclk.
*/
`ifndef CPMC_CONSTS_VH
`define CPMC_CONSTS_VH
// ==========================================
// register byte offsets on apb
`define CPMC_OFF_TABLE_POINTER_LOW 12'h000
`define CPMC_OFF_LVCTL 12'h004
`define CPMC_OFF_SYSCTL 12'h008
`define CPMC_OFF_LVSTAT 12'h00c
`define CPMC_OFF_MODE 12'h010
`define CPMC_OFF_GPR_LO 12'h040
`define CPMC_OFF_GPR_HI 12'h0fc
// ==========================================
// field positions
`define CPMC_LV_IRQ_EN 7
`define CPMC_LV_DET_EN 6
`define CPMC_LV_LVL_HI 5
`define CPMC_LV_LVL_LO 4
`define CPMC_LV_EXT_WAKE 0
`define CPMC_SC_TIMER_SEL 6
`define CPMC_SC_CORE_SEL 5
`define CPMC_SC_IDLE_EN 4
`define CPMC_ST_SUPPLY_OK 7
`define CPMC_ST_IRQ_FLAG 6
`define CPMC_ST_RESET_TYPE 5
// ==========================================
// reset values
`define CPMC_LVCTL_RST 8'h00
`define CPMC_SYSCTL_RST 8'h60
// ==========================================
// timing: clock rate and printed times
`define CPMC_CLK_MHZ 250
`define CPMC_CNT_XTAL_NORMAL 510
`define CPMC_CNT_OTHER 8
`define CPMC_STABLE_4M_NS 5000
`define CPMC_STABLE_16M_NS 1500
`define CPMC_STABLE_8M_NS 3000
`define CPMC_STABLE_1M_NS 24000
`define CPMC_CYC(ns) (((ns) * `CPMC_CLK_MHZ) / 1000)
`endif

// [rtl/cpmc_counter.v]
/*
 down counter: loads a count and pulses done when it reaches zero.
 assumes a single clock and an active-low asynchronous reset.
*/
`timescale 1ns/10ps
`include "cpmc_consts.vh"
module cpmc_counter #(
	parameter WIDTH = 13
) (
	input wire pclk,
	input wire presetn,
	input wire load,
	input wire [WIDTH-1:0] value,
	input wire enable,
	output wire busy,
	output reg done_ff
);
	reg [WIDTH-1:0] cnt_ff;
	// ==========================================
	// count down while enabled
	assign busy = (cnt_ff != {WIDTH{1'b0}}) | load;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= {WIDTH{1'b0}};
			done_ff <= 1'b0;
		end else if (load) begin
			cnt_ff <= value;
			done_ff <= 1'b0;
		end else if (enable && cnt_ff != {WIDTH{1'b0}}) begin
			cnt_ff <= cnt_ff - {{(WIDTH-1){1'b0}}, 1'b1};
			done_ff <= (cnt_ff == {{(WIDTH-1){1'b0}}, 1'b1});
		end else begin
			done_ff <= 1'b0;
		end
	end
endmodule // cpmc_counter

// [rtl/cpmc_gpr.v]
/*
 general-purpose byte storage, flip-flops addressed by index.
 assumes writes are qualified by the bus slave.
*/
`timescale 1ns/10ps
module cpmc_gpr #(
	parameter DEPTH = 48,
	parameter AW = 6
) (
	input wire pclk,
	input wire presetn,
	input wire wr_en,
	input wire [AW-1:0] idx,
	input wire [7:0] wdata,
	output wire [7:0] rdata
);
	reg [7:0] mem_ff [0:DEPTH-1];
	integer i;
	// ==========================================
	// byte array with reset
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (i = 0; i < DEPTH; i = i + 1)
				mem_ff[i] <= 8'h00;
		end else if (wr_en) begin
			mem_ff[idx] <= wdata;
		end
	end
	assign rdata = mem_ff[idx];
endmodule // cpmc_gpr

// [rtl/cpmc_top.v]
/*
 clock and power-mode control: table pointer, low-voltage detector control,
 system clock control, sleep/idle sequencing, wake-up counts, rc frequency
 hold, and general-purpose bytes, all on an apb slave.
 assumes synchronous analog inputs and one 250 MHz clock.
*/
// Decided for this implementation: the APB register port and the register addresses.
// Operation
// - table pointer register holds low eight program address bits for table reads.
// - low-voltage control bit 7 gates the detector interrupt request.
// - bit 6 enables the detector; off means level has no effect.
// - bits 5..4 select trip level; status reads 0 at or below level.
// - interrupt is raised on each crossing of the trip level, either way.
// - low-voltage control bits 3..1 read as zero.
// - bit 0 enables wake from low power by the external pin.
// - system control bits 7, 3 and 2 read as zero.
// - timer clock bit 6: 0 sub clock, 1 main clock; reset 1.
// - core clock bit 5: 0 sub-oscillator, 1 main oscillator; reset main.
// - main oscillator stops while the core runs on the sub-oscillator.
// - sleep instruction enters sleep if idle bit 0, idle if 1.
// - after oscillator stable, count 510 clocks for crystal normal, else 8.
// - rc frequency field: 11 4MHz, 10 16MHz, 01 8MHz, 00 1MHz.
// - rc frequency field resets from configuration word bits 6 and 5.
// - changing rc frequency holds execution for the new frequency's stable time; the code holds only for writes made while running or during an rc hold.
// - data addresses 0x10 to 0x3f are plain read/write bytes.
// - low-voltage interrupt flag sets on detector interrupt, reads 1 while pending.
// - wake from sleep by pin, external or low-voltage interrupt sets reset type.
`timescale 1ns/10ps
`include "cpmc_consts.vh"
module cpmc_top #(
	parameter OSC_STABLE_CYC = 500000,
	parameter CNT_W = 20
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire [1:0] cfg_rc_freq,
	input wire osc_is_crystal,
	input wire sleep_instruction,
	input wire supply_below_level,
	input wire ext_pin_wake,
	input wire pin_change_wake,
	output reg [7:0] table_pointer_low,
	output wire core_clock_select,
	output wire timer_clock_select,
	output wire [1:0] rc_freq_select,
	output wire [1:0] low_voltage_level,
	output wire low_voltage_detector_enable,
	output wire low_voltage_irq,
	output reg main_osc_enable,
	output reg core_clock_enable,
	output reg exec_hold,
	output reg [1:0] power_mode
);
	// ==========================================
	// modes and hold sequencer states
	localparam MODE_RUN = 2'b00;
	localparam MODE_SLEEP = 2'b01;
	localparam MODE_IDLE = 2'b10;
	localparam ST_RUN = 3'd0;
	localparam ST_SLEEP = 3'd1;
	localparam ST_IDLE = 3'd2;
	localparam ST_STABLE = 3'd3;
	localparam ST_COUNT = 3'd4;
	localparam ST_RCHOLD = 3'd5;
	// ==========================================
	// hold and wait counts, worked out as integers first
	// and cut to the counter width on purpose, so a
	// narrower counter width truncates them with no warning
	localparam integer CYC_4M_I = `CPMC_CYC(`CPMC_STABLE_4M_NS);
	localparam integer CYC_16M_I = `CPMC_CYC(`CPMC_STABLE_16M_NS);
	localparam integer CYC_8M_I = `CPMC_CYC(`CPMC_STABLE_8M_NS);
	localparam integer CYC_1M_I = `CPMC_CYC(`CPMC_STABLE_1M_NS);
	localparam integer CYC_XTAL_I = `CPMC_CNT_XTAL_NORMAL;
	localparam integer CYC_OTHER_I = `CPMC_CNT_OTHER;
	localparam integer CYC_OSC_I = OSC_STABLE_CYC;
	localparam [CNT_W-1:0] CYC_4M = CYC_4M_I[CNT_W-1:0];
	localparam [CNT_W-1:0] CYC_16M = CYC_16M_I[CNT_W-1:0];
	localparam [CNT_W-1:0] CYC_8M = CYC_8M_I[CNT_W-1:0];
	localparam [CNT_W-1:0] CYC_1M = CYC_1M_I[CNT_W-1:0];
	localparam [CNT_W-1:0] CYC_XTAL = CYC_XTAL_I[CNT_W-1:0];
	localparam [CNT_W-1:0] CYC_OTHER = CYC_OTHER_I[CNT_W-1:0];
	localparam [CNT_W-1:0] CYC_OSC = CYC_OSC_I[CNT_W-1:0];

	reg [7:0] lvctl_ff;
	reg [7:0] sysctl_ff;
	reg lv_flag_ff;
	reg reset_type_ff;
	reg below_ff;
	reg cfg_done_ff;
	reg [2:0] st_ff;
	reg [2:0] nxt_st;
	reg cnt_load;
	reg [CNT_W-1:0] cnt_val;
	reg [CNT_W-1:0] rc_hold_val;
	reg wake_from_sleep_ff;
	wire cnt_busy;
	wire cnt_done;
	wire [7:0] gpr_rdata;
	wire acc;
	wire wr;
	wire hit_gpr;
	wire [5:0] gpr_idx;
	wire lv_cross;
	wire wake_evt;
	wire rc_write;

	// ==========================================
	// apb slave: zero-wait, error on unmapped address
	assign acc = psel & penable;
	assign wr = acc & pwrite & pstrb[0];
	assign pready = 1'b1;
	assign hit_gpr = (paddr >= `CPMC_OFF_GPR_LO) && (paddr <= `CPMC_OFF_GPR_HI) && (paddr[1:0] == 2'b00);
	assign gpr_idx = paddr[7:2] - 6'h10;
	assign pslverr = acc & ~hit_gpr & (paddr != `CPMC_OFF_TABLE_POINTER_LOW) & (paddr != `CPMC_OFF_LVCTL)
		& (paddr != `CPMC_OFF_SYSCTL) & (paddr != `CPMC_OFF_LVSTAT) & (paddr != `CPMC_OFF_MODE);
	assign rc_write = wr && (paddr == `CPMC_OFF_SYSCTL) && (pwdata[1:0] != sysctl_ff[1:0]);

	// ==========================================
	// general-purpose bytes
	cpmc_gpr #(
		.DEPTH(48),
		.AW(6)
	) u_gpr (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(wr & hit_gpr),
		.idx(gpr_idx),
		.wdata(pwdata[7:0]),
		.rdata(gpr_rdata)
	);

	// ==========================================
	// read data mux, reserved bits zero
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else begin
			prdata <= 32'h00000000;
			if (psel && !penable && !pwrite) begin
				if (paddr == `CPMC_OFF_TABLE_POINTER_LOW)
					prdata <= {24'h000000, table_pointer_low};
				else if (paddr == `CPMC_OFF_LVCTL)
					prdata <= {24'h000000, lvctl_ff[7:4], 3'b000, lvctl_ff[0]};
				else if (paddr == `CPMC_OFF_SYSCTL)
					prdata <= {24'h000000, 1'b0, sysctl_ff[6:4], 2'b00, sysctl_ff[1:0]};
				else if (paddr == `CPMC_OFF_LVSTAT)
					prdata <= {24'h000000, ~(below_ff & lvctl_ff[`CPMC_LV_DET_EN]), lv_flag_ff,
						reset_type_ff, 5'b00000};
				else if (paddr == `CPMC_OFF_MODE)
					prdata <= {24'h000000, 3'b000, st_ff, power_mode};
				else if (hit_gpr)
					prdata <= {24'h000000, gpr_rdata};
			end
		end
	end

	// ==========================================
	// writable control registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			table_pointer_low <= 8'h00;
			lvctl_ff <= `CPMC_LVCTL_RST;
			sysctl_ff <= `CPMC_SYSCTL_RST;
			cfg_done_ff <= 1'b0;
		end else begin
			cfg_done_ff <= 1'b1;
			if (!cfg_done_ff)
				sysctl_ff[1:0] <= cfg_rc_freq;
			else if (wr && paddr == `CPMC_OFF_SYSCTL)
				sysctl_ff <= {1'b0, pwdata[6:4], 2'b00, pwdata[1:0]};
			if (wr && paddr == `CPMC_OFF_TABLE_POINTER_LOW)
				table_pointer_low <= pwdata[7:0];
			if (wr && paddr == `CPMC_OFF_LVCTL)
				lvctl_ff <= {pwdata[7:4], 3'b000, pwdata[0]};
		end
	end
	assign timer_clock_select = sysctl_ff[`CPMC_SC_TIMER_SEL];
	assign core_clock_select = sysctl_ff[`CPMC_SC_CORE_SEL];
	assign rc_freq_select = sysctl_ff[1:0];
	assign low_voltage_level = lvctl_ff[`CPMC_LV_LVL_HI:`CPMC_LV_LVL_LO];
	assign low_voltage_detector_enable = lvctl_ff[`CPMC_LV_DET_EN];

	// ==========================================
	// low-voltage crossing detect and sticky flag
	assign lv_cross = lvctl_ff[`CPMC_LV_DET_EN] & (supply_below_level ^ below_ff);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			below_ff <= 1'b0;
			lv_flag_ff <= 1'b0;
		end else begin
			below_ff <= supply_below_level & lvctl_ff[`CPMC_LV_DET_EN];
			if (lv_cross)
				lv_flag_ff <= 1'b1;
			else if (wr && paddr == `CPMC_OFF_LVSTAT && !pwdata[`CPMC_ST_IRQ_FLAG])
				lv_flag_ff <= 1'b0; // set wins over clear
		end
	end
	assign low_voltage_irq = lv_flag_ff & lvctl_ff[`CPMC_LV_IRQ_EN];

	// ==========================================
	// wake sources
	assign wake_evt = (ext_pin_wake & lvctl_ff[`CPMC_LV_EXT_WAKE]) | pin_change_wake
		| (lv_cross & lvctl_ff[`CPMC_LV_IRQ_EN]);

	// ==========================================
	// hold / wait counter
	cpmc_counter #(
		.WIDTH(CNT_W)
	) u_cnt (
		.pclk(pclk),
		.presetn(presetn),
		.load(cnt_load),
		.value(cnt_val),
		.enable(1'b1),
		.busy(cnt_busy),
		.done_ff(cnt_done)
	);

	// ==========================================
	// stable time of the newly written rc frequency
	// the hold is timed by the target, not the source
	always @* begin
		case (pwdata[1:0])
		2'b11: rc_hold_val = CYC_4M;
		2'b10: rc_hold_val = CYC_16M;
		2'b01: rc_hold_val = CYC_8M;
		default: rc_hold_val = CYC_1M;
		endcase
	end

	// ==========================================
	// power mode sequencer next state
	// an rc write while running starts the rc hold and one
	// during it restarts it; writes in sleep, idle or a wake-up wait start none
	always @* begin
		nxt_st = st_ff;
		cnt_load = 1'b0;
		cnt_val = {CNT_W{1'b0}};
		case (st_ff)
		ST_RUN: begin
			if (rc_write) begin
				nxt_st = ST_RCHOLD;
				cnt_load = 1'b1;
				cnt_val = rc_hold_val;
			end else if (sleep_instruction) begin
				nxt_st = sysctl_ff[`CPMC_SC_IDLE_EN] ? ST_IDLE : ST_SLEEP;
			end
		end
		ST_SLEEP, ST_IDLE: begin
			if (wake_evt) begin
				nxt_st = ST_STABLE;
				cnt_load = 1'b1;
				cnt_val = CYC_OSC;
			end
		end
		ST_STABLE: begin
			if (cnt_done) begin
				nxt_st = ST_COUNT;
				cnt_load = 1'b1;
				cnt_val = (osc_is_crystal && core_clock_select) ? CYC_XTAL : CYC_OTHER;
			end
		end
		ST_COUNT: begin
			if (cnt_done)
				nxt_st = ST_RUN;
		end
		ST_RCHOLD: begin
			if (rc_write) begin
				cnt_load = 1'b1;
				cnt_val = rc_hold_val;
			end else if (cnt_done) begin
				nxt_st = ST_RUN;
			end
		end
		default: nxt_st = ST_RUN;
		endcase
	end

	// ==========================================
	// sequencer state, clocks and reset-type flag
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= ST_RUN;
			wake_from_sleep_ff <= 1'b0;
			reset_type_ff <= 1'b0;
			main_osc_enable <= 1'b1;
			core_clock_enable <= 1'b1;
			exec_hold <= 1'b0;
			power_mode <= MODE_RUN;
		end else begin
			st_ff <= nxt_st;
			if (st_ff == ST_SLEEP && wake_evt) begin
				wake_from_sleep_ff <= 1'b1;
				reset_type_ff <= 1'b1;
			end else if (st_ff == ST_IDLE && wake_evt) begin
				wake_from_sleep_ff <= 1'b0;
			end
			main_osc_enable <= core_clock_select && (nxt_st != ST_SLEEP);
			core_clock_enable <= (nxt_st == ST_RUN);
			exec_hold <= (nxt_st != ST_RUN);
			if (nxt_st == ST_SLEEP)
				power_mode <= MODE_SLEEP;
			else if (nxt_st == ST_IDLE)
				power_mode <= MODE_IDLE;
			else
				power_mode <= MODE_RUN;
		end
	end
endmodule // cpmc_top

// [test/cpmc_chk.sv]
/* port checker for cpmc_top.
 bound to every cpmc_top; one clock domain. */
`timescale 1ns/10ps
// ==========
// checker
module cpmc_chk (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	input wire pslverr,
	input wire sleep_instruction,
	input wire core_clock_select,
	input wire [1:0] rc_freq_select,
	input wire main_osc_enable,
	input wire core_clock_enable,
	input wire exec_hold,
	input wire [1:0] power_mode
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// a hold run and a stay in low power
	sequence s_held;
		exec_hold [*8];
	endsequence
	sequence s_low;
		(power_mode != 2'b00) [*2];
	endsequence
	a_upper_zero: assert property (prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_hole_err: assert property (psel && penable && paddr == 12'h020 |-> pslverr)
		else $error("no error on hole");
	a_gpr_ok: assert property (psel && penable && paddr == 12'h0fc |-> !pslverr)
		else $error("error on storage");
	a_sleep_entry: assert property (power_mode == 2'b00 && !exec_hold && sleep_instruction |=> power_mode != 2'b00)
		else $error("sleep not entered");
	a_sleep_halt: assert property ($rose(power_mode == 2'b01) |-> ##1 !core_clock_enable && !main_osc_enable)
		else $error("clocks run in sleep");
	a_idle_halt: assert property ($rose(power_mode == 2'b10) && core_clock_select |-> ##1 !core_clock_enable && main_osc_enable)
		else $error("idle clocks wrong");
	a_sub_stop: assert property ((!core_clock_select) [*2] |-> !main_osc_enable)
		else $error("main osc runs on sub");
	a_rc_hold: assert property ($changed(rc_freq_select) && $past(presetn, 2) |-> ##[0:1] s_held)
		else $error("no hold on rc change");
	a_low_held: assert property (s_low |-> exec_hold)
		else $error("core not held");
endmodule // cpmc_chk
bind cpmc_top cpmc_chk chk_u (.*);

// [test/cpmc_lv_model.sv]
/* comparator model: supply in mV against the trip level.
 driven by the bench; samples once per pclk. */
`timescale 1ns/10ps
// ==========
// comparator
module cpmc_lv_model (
	input wire pclk,
	input wire [1:0] low_voltage_level,
	input wire [15:0] supply_mv,
	output reg supply_below_level = 1'b0
);
	reg [15:0] trip;
	// trip level per code
	always @* begin
		case (low_voltage_level)
			2'b11: trip = 16'd2200;
			2'b10: trip = 16'd3300;
			2'b01: trip = 16'd4000;
			default: trip = 16'd4500;
		endcase
	end
	// at or below the level trips
	always @(posedge pclk) begin
		supply_below_level <= supply_mv <= trip;
	end
endmodule // cpmc_lv_model

// [test/cpmc_tb.sv]
/* bench for cpmc_top: registers, sleep, idle, wake counts, rc hold, detector.
 pairs the design with the comparator model. */
`timescale 1ns/10ps
// ==========
// bench top
module testbench;
	localparam STB = 20;
	reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	reg [11:0] paddr = 12'h000;
	reg [31:0] pwdata = 32'h0, r;
	reg [1:0] cfg_rc_freq = 2'b10;
	reg osc_is_crystal = 1'b1, sleep_instruction = 1'b0, ext_pin_wake = 1'b0, pin_change_wake = 1'b0, e;
	reg [15:0] supply_mv = 16'd5000;
	reg [28:0] rows [0:5];
	reg [15:0] trip [0:3];
	integer hold_cyc [0:3];
	integer mismatches = 0, n_compared = 0, cyc = 0, i, n;
	wire [3:0] pstrb = 4'h1;
	wire [31:0] prdata;
	wire [7:0] table_pointer_low;
	wire [1:0] rc_freq_select, low_voltage_level, power_mode;
	wire pready, pslverr, supply_below_level, core_clock_select, timer_clock_select;
	wire low_voltage_detector_enable, low_voltage_irq, main_osc_enable, core_clock_enable, exec_hold;
	cpmc_top #(.OSC_STABLE_CYC(STB)) dut_u (.*);
	cpmc_lv_model lv_u (.*);
	// 250 MHz clock
	always #2 pclk = ~pclk;
	// cycle ceiling
	always @(posedge pclk) begin
		cyc = cyc + 1;
		if (cyc == 40000) begin
			mismatches = mismatches + 1;
			print_verdict;
		end
	end
	task print_verdict;
		begin
			if (mismatches == 0 && n_compared > 0) begin
				$display("[ PASS ]");
			end else begin
				$display("[ FAIL ]");
			end
			$finish;
		end
	endtask
	task chk(input string name, input [31:0] seen, input [31:0] exp);
		begin
			n_compared = n_compared + 1;
			if (seen !== exp) begin
				mismatches = mismatches + 1;
				$display("ERROR %s expected %h seen %h", name, exp, seen);
			end
		end
	endtask
	// one apb transfer
	task apb(input [11:0] a, input w, input [7:0] d);
		begin
			@(posedge pclk);
			psel <= 1'b1;
			paddr <= a;
			pwrite <= w;
			pwdata <= {24'h0, d};
			@(posedge pclk);
			penable <= 1'b1;
			@(posedge pclk);
			while (pready !== 1'b1) @(posedge pclk);
			r = prdata;
			e = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	// cycles until running and not held
	task wait_run;
		begin
			n = 0;
			@(negedge pclk);
			while ((power_mode !== 2'b00 || exec_hold !== 1'b0) && n < 9000) begin
				@(negedge pclk);
				n = n + 1;
			end
		end
	endtask
	task pulse(input [2:0] which);
		begin
			@(posedge pclk);
			{sleep_instruction, ext_pin_wake, pin_change_wake} <= which;
			@(posedge pclk);
			{sleep_instruction, ext_pin_wake, pin_change_wake} <= 3'b000;
		end
	endtask
	initial begin
		rows[0] = {1'b0, 12'h000, 8'ha5, 8'ha5};
		rows[1] = {1'b0, 12'h004, 8'hff, 8'hf1};
		rows[2] = {1'b0, 12'h008, 8'hff, 8'h73};
		rows[3] = {1'b0, 12'h040, 8'h3c, 8'h3c};
		rows[4] = {1'b0, 12'h0fc, 8'hc3, 8'hc3};
		rows[5] = {1'b1, 12'h020, 8'h5a, 8'h00};
		trip = '{16'd4500, 16'd4000, 16'd3300, 16'd2200};
		hold_cyc = '{6000, 750, 375, 1250};
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		apb(12'h008, 1'b0, 8'h00);
		chk("sysctl_rst", r, 32'h62);
		apb(12'h004, 1'b0, 8'h00);
		chk("lvctl_rst", r, 32'h0);
		chk("mode_rst", {power_mode, main_osc_enable, core_clock_enable, exec_hold}, 32'h6);
		chk("apb_idle", {pready, pslverr}, 32'h2);
		// register rows
		for (i = 0; i < 6; i = i + 1) begin
			apb(rows[i][27:16], 1'b1, rows[i][15:8]);
			apb(rows[i][27:16], 1'b0, 8'h00);
			chk("row_data", r, {24'h0, rows[i][7:0]});
			chk("row_err", e, rows[i][28]);
		end
		chk("table_port", {24'h0, table_pointer_low}, 32'ha5);
		chk("lv_ports", {low_voltage_level, low_voltage_detector_enable}, 32'h7);
		// every rc code holds for its own time
		wait_run;
		for (i = 0; i < 4; i = i + 1) begin
			apb(12'h008, 1'b1, 8'h60 | i[7:0]);
			wait_run;
			chk("rc_hold", n >= hold_cyc[i] - 1 && n <= hold_cyc[i] + 3, 32'h1);
			chk("rc_sel", {30'h0, rc_freq_select}, i);
		end
		// sleep, masked pin, then pin wake
		apb(12'h004, 1'b1, 8'h00);
		pulse(3'b100);
		repeat (2) @(negedge pclk);
		chk("sleep", {power_mode, main_osc_enable, core_clock_enable, exec_hold}, 32'h9);
		pulse(3'b010);
		repeat (40) @(negedge pclk);
		chk("no_wake", {30'h0, power_mode}, 32'h1);
		apb(12'h004, 1'b1, 8'h01);
		pulse(3'b010);
		wait_run;
		chk("xtal_wake", n >= STB + 505 && n <= STB + 516, 32'h1);
		apb(12'h00c, 1'b0, 8'h00);
		chk("reset_type", r[7:5], 32'h5);
		// idle keeps the oscillator; short count
		apb(12'h008, 1'b1, 8'h73);
		osc_is_crystal <= 1'b0;
		pulse(3'b100);
		repeat (2) @(negedge pclk);
		chk("idle", {power_mode, main_osc_enable, core_clock_enable, exec_hold}, 32'h15);
		pulse(3'b001);
		wait_run;
		chk("rc_wake", n >= STB + 4 && n <= STB + 12, 32'h1);
		// core and timer clock selects
		apb(12'h008, 1'b1, 8'h53);
		repeat (2) @(negedge pclk);
		chk("core_sub", {core_clock_select, timer_clock_select, main_osc_enable}, 32'h2);
		apb(12'h008, 1'b1, 8'h23);
		repeat (2) @(negedge pclk);
		chk("core_main", {core_clock_select, timer_clock_select, main_osc_enable}, 32'h5);
		// each level, crossings both ways
		for (i = 0; i < 4; i = i + 1) begin
			apb(12'h004, 1'b1, 8'hc0 | (i[7:0] << 4));
			supply_mv <= trip[i] - 16'd100;
			repeat (4) @(negedge pclk);
			chk("irq_below", low_voltage_irq, 32'h1);
			apb(12'h00c, 1'b0, 8'h00);
			chk("st_below", r[7:6], 32'h1);
			apb(12'h00c, 1'b1, 8'h00);
			supply_mv <= trip[i] + 16'd100;
			repeat (4) @(negedge pclk);
			apb(12'h00c, 1'b0, 8'h00);
			chk("st_above", r[7:6], 32'h3);
			apb(12'h00c, 1'b1, 8'h00);
		end
		@(negedge pclk);
		chk("irq_clr", low_voltage_irq, 32'h0);
		apb(12'h004, 1'b1, 8'h70);
		supply_mv <= 16'd2000;
		repeat (4) @(negedge pclk);
		chk("irq_mask", low_voltage_irq, 32'h0);
		apb(12'h004, 1'b1, 8'h30);
		apb(12'h00c, 1'b0, 8'h00);
		chk("det_off", r[7:6], 32'h3);
		// mid-run reset reloads rc field
		cfg_rc_freq <= 2'b01;
		presetn <= 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(negedge pclk);
		chk("rc_cfg", {rc_freq_select, table_pointer_low}, 32'h100);
		print_verdict;
	end
endmodule // testbench
